/* src/cml_pkg.sv */
// Purpose: Shared constants for the calibration memory lock and access block.
// Assumes: One 25 MHz clock; commands arrive already decoded from the supply link.
// Notes:   Address map of the calibration memory and output format codes.
package cml_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned PWM_PERIOD_US = 8000;
    localparam int unsigned PWM_PERIOD_CYC = (CLK_HZ / 1_000_000) * PWM_PERIOD_US;
    localparam int unsigned PWM_RES_BITS = 11;
    localparam int unsigned PWM_STEP_CYC = PWM_PERIOD_CYC / (1 << PWM_RES_BITS);

    // ****************************************
    // Memory map (word addresses)
    // ****************************************
    localparam int unsigned AW            = 5;
    localparam int unsigned DW            = 16;
    localparam logic [4:0]  ADDR_MODE     = 5'h00;
    localparam logic [4:0]  ADDR_SEAL     = 5'h1F;
    localparam logic [4:0]  ADDR_TRACK_LO = 5'h18;
    localparam logic [4:0]  ADDR_ADC_RD   = 5'h1E;
    localparam int unsigned FMT_LSB       = 5;

    // ****************************************
    // Output format codes and reply codes
    // ****************************************
    localparam logic [2:0]  FMT_PWM       = 3'h6;
    localparam logic [2:0]  FMT_PWM_INV   = 3'h7;
    localparam logic [15:0] NACK_WORD     = 16'hDEAD;
    localparam logic [15:0] MODE_RESET    = 16'h0000;

    typedef enum logic [1:0] {
        CML_IDLE  = 2'b00,
        CML_READ  = 2'b01,
        CML_REPLY = 2'b10
    } cml_state_t;
endpackage : cml_pkg

/* src/cml_mem_if.sv */
// Purpose: Carrier between the access controller and the redundant memory.
// Assumes: Single clock.
// Notes:   Read data valid one cycle after a read strobe.
`timescale 1ns/10ps
interface cml_mem_if;
    logic                         we;
    logic                         re;
    logic [cml_pkg::AW-1:0]       addr;
    logic [cml_pkg::DW-1:0]       wdata;
    logic [cml_pkg::DW-1:0]       rdata;
    logic                         fault;
    modport ctrl (output we, re, addr, wdata, input rdata, fault);
    modport mem  (input we, re, addr, wdata, output rdata, fault);
endinterface : cml_mem_if

/* src/cml_mem.sv */
// Purpose: Calibration memory with redundant cells for configuration data.
// Assumes: Contents are held outside reset; a real part keeps them in nonvolatile cells.
// Notes:   Tracking words from ADDR_TRACK_LO up, except the seal word, are single copies.
`timescale 1ns/10ps
module cml_mem (
    // Clock
    input wire logic clk,
    input wire logic ce,
    // Memory port
    cml_mem_if.mem   m
);
    logic [cml_pkg::DW-1:0] copy_a [0:(1<<cml_pkg::AW)-1];
    logic [cml_pkg::DW-1:0] copy_b [0:(1<<cml_pkg::AW)-1];
    logic [cml_pkg::DW-1:0] rdata_r;
    logic                   fault_r;
    wire                    is_track = (m.addr >= cml_pkg::ADDR_TRACK_LO) && (m.addr != cml_pkg::ADDR_SEAL);

    // ****************************************
    // Storage
    // ****************************************
    // Configuration words are written to both copies; tracking only to one.
    always_ff @(posedge clk) begin
        if (ce && m.we) begin
            copy_a[m.addr] <= m.wdata;
            if (!is_track) begin
                copy_b[m.addr] <= m.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce && m.re) begin
            rdata_r <= copy_a[m.addr];
            fault_r <= !is_track && (copy_a[m.addr] != copy_b[m.addr]);
        end
    end

    assign m.rdata = rdata_r;
    assign m.fault = fault_r;
endmodule : cml_mem

/* src/cml_access.sv */
// Purpose: Access control for the calibration memory and the shared output driver.
// Assumes: Commands come decoded from the supply-link decoder on the same clock.
// Notes:   Seal state is captured in a flop that only ever sets.
`timescale 1ns/10ps
module cml_access #(
    parameter int unsigned PWM_STEP = cml_pkg::PWM_STEP_CYC
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    // Decoded command from the link decoder
    input  wire logic                   cmd_valid,
    input  wire logic                   cmd_write,
    input  wire logic [cml_pkg::AW-1:0] cmd_addr,
    input  wire logic [cml_pkg::DW-1:0] cmd_wdata,
    // Selection pin level from outside
    input  wire logic                   sel_pin,
    // Converter stream
    input  wire logic [cml_pkg::DW-1:0] adc_filtered,
    // Digital bit from the reply encoder
    input  wire logic                   reply_bit,
    input  wire logic                   reply_done,
    // Answers
    output logic                        reply_valid,
    output logic [cml_pkg::DW-1:0]      reply_data,
    output logic                        reply_nack,
    output logic                        digital_sel,
    output logic                        pin_digital,
    output logic                        sealed,
    output logic                        mem_fault,
    output logic [2:0]                  out_format
);
    cml_mem_if mif ();

    cml_mem u_mem (
        .clk (clk),
        .ce  (ce),
        .m   (mif.mem)
    );

    // ****************************************
    // Selection synchroniser
    // ****************************************
    logic sel_s1_r;
    logic sel_s2_r;
    logic sel_s3_r;
    logic selected_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_s1_r <= 1'b0;
            sel_s2_r <= 1'b0;
            sel_s3_r <= 1'b0;
        end else if (ce) begin
            sel_s1_r <= sel_pin;
            sel_s2_r <= sel_s1_r;
            sel_s3_r <= sel_s2_r;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            selected_r <= 1'b0;
        end else if (ce && (sel_s2_r == sel_s3_r)) begin
            selected_r <= sel_s3_r;
        end
    end

    // ****************************************
    // Seal and format state
    // ****************************************
    // The seal flop has no reset branch; it is recovered from memory after
    // reset by a scan of the seal word, so a reset can never unseal the part.
    // Simulation starts unsealed; a real part keeps the seal in a nonvolatile cell.
    cml_pkg::cml_state_t state_r;
    cml_pkg::cml_state_t state_nxt;
    logic                seal_r = 1'b0;
    logic                seal_load_r;
    logic [2:0]          fmt_r;
    wire        take     = cmd_valid && selected_r;
    wire        blocked  = seal_r;
    wire        do_write = take && cmd_write && !blocked && (state_r == cml_pkg::CML_IDLE);
    wire        do_read  = take && !cmd_write && (state_r == cml_pkg::CML_IDLE);
    wire        seal_set = do_write && (cmd_addr == cml_pkg::ADDR_SEAL) && cmd_wdata[0];
    wire        fmt_set  = do_write && (cmd_addr == cml_pkg::ADDR_MODE);

    always_ff @(posedge clk) begin
        if (ce && (seal_set || (seal_load_r && mif.rdata[0]))) begin
            seal_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seal_load_r <= 1'b1;
        end else if (ce) begin
            seal_load_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fmt_r <= 3'h0;
        end else if (ce && fmt_set) begin
            fmt_r <= cmd_wdata[cml_pkg::FMT_LSB +: 3];
        end
    end

    // ****************************************
    // Memory port
    // ****************************************
    assign mif.we    = do_write;
    assign mif.re    = (do_read && !blocked) || seal_load_r;
    assign mif.addr  = seal_load_r ? cml_pkg::ADDR_SEAL : cmd_addr;
    assign mif.wdata = cmd_wdata;

    // ****************************************
    // Command sequencer
    // ****************************************
    logic                   rd_adc_r;
    logic                   rd_nack_r;
    logic [cml_pkg::DW-1:0] adc_snap_r;
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            cml_pkg::CML_IDLE:  if (take) state_nxt = cmd_write ? cml_pkg::CML_REPLY : cml_pkg::CML_READ;
            cml_pkg::CML_READ:  state_nxt = cml_pkg::CML_REPLY;
            cml_pkg::CML_REPLY: if (reply_done) state_nxt = cml_pkg::CML_IDLE;
            default:            state_nxt = cml_pkg::CML_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r    <= cml_pkg::CML_IDLE;
            rd_adc_r   <= 1'b0;
            rd_nack_r  <= 1'b0;
            adc_snap_r <= 16'h0000;
        end else if (ce) begin
            state_r <= state_nxt;
            if (state_r == cml_pkg::CML_IDLE && take) begin
                rd_adc_r   <= (cmd_addr == cml_pkg::ADDR_ADC_RD);
                rd_nack_r  <= blocked;
                adc_snap_r <= adc_filtered;
            end
        end
    end

    // ****************************************
    // Replies
    // ****************************************
    wire                   reply_go  = (state_r == cml_pkg::CML_READ) || (state_r == cml_pkg::CML_IDLE && take && cmd_write);
    wire                   go_nack   = (state_r == cml_pkg::CML_READ) ? rd_nack_r : blocked;
    wire [cml_pkg::DW-1:0] read_word = rd_adc_r ? adc_snap_r : mif.rdata;
    wire [cml_pkg::DW-1:0] go_data   = go_nack ? cml_pkg::NACK_WORD :
                                       ((state_r == cml_pkg::CML_READ) ? read_word : cmd_wdata);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reply_valid <= 1'b0;
            reply_data  <= 16'h0000;
            reply_nack  <= 1'b0;
        end else if (ce) begin
            reply_valid <= reply_go;
            if (reply_go) begin
                reply_data <= go_data;
                reply_nack <= go_nack;
            end
        end
    end

    // ****************************************
    // Pulse-width generator
    // ****************************************
    // Duty uses the top 11 bits of the converter stream so the resolution is fixed
    // regardless of the converter width.
    localparam int unsigned PW = cml_pkg::PWM_RES_BITS;
    logic [PW-1:0] slot_r;
    logic [15:0]   step_r;
    logic [PW-1:0] duty_r;
    logic          pwm_r;
    wire           pwm_mode = (fmt_r == cml_pkg::FMT_PWM) || (fmt_r == cml_pkg::FMT_PWM_INV);
    wire           step_end = (step_r == 16'(PWM_STEP - 1));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_r <= 16'h0000;
            slot_r <= 11'h000;
            duty_r <= 11'h000;
            pwm_r  <= 1'b0;
        end else if (ce) begin
            step_r <= step_end ? 16'h0000 : step_r + 16'h0001;
            if (step_end) begin
                slot_r <= slot_r + 11'h001;
                if (slot_r == 11'h7FF) begin
                    duty_r <= adc_filtered[cml_pkg::DW-1 -: PW];
                end
            end
            pwm_r <= (slot_r < duty_r) ^ (fmt_r == cml_pkg::FMT_PWM_INV);
        end
    end

    // ****************************************
    // Shared digital output driver
    // ****************************************
    wire exch = (state_nxt != cml_pkg::CML_IDLE);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            digital_sel <= 1'b0;
            pin_digital <= 1'b0;
            sealed      <= 1'b0;
            mem_fault   <= 1'b0;
            out_format  <= 3'h0;
        end else if (ce) begin
            digital_sel <= exch || pwm_mode;
            pin_digital <= exch ? reply_bit : pwm_r;
            sealed      <= seal_r;
            mem_fault   <= mif.fault;
            out_format  <= fmt_r;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_seal_sticky: assert property (@(posedge clk) disable iff (rst) seal_r |=> seal_r)
        else $error("seal bit cleared");
    a_sealed_no_write: assert property (@(posedge clk) disable iff (rst) seal_r |-> !mif.we)
        else $error("write while sealed");
    a_sealed_nack: assert property (@(posedge clk) disable iff (rst)
        (ce && seal_r && take && state_r == cml_pkg::CML_IDLE && !cmd_write) |-> ##2 (reply_valid && reply_nack))
        else $error("sealed read not refused");
    a_unsel_ignored: assert property (@(posedge clk) disable iff (rst)
        (ce && cmd_valid && !selected_r && state_r == cml_pkg::CML_IDLE) |=> state_r == cml_pkg::CML_IDLE)
        else $error("unselected command taken");
    a_write_reply: assert property (@(posedge clk) disable iff (rst)
        (ce && do_write) |=> (reply_valid && !reply_nack && reply_data == $past(cmd_wdata)))
        else $error("write reply missing");
    a_exch_digital: assert property (@(posedge clk) disable iff (rst)
        (ce && state_r == cml_pkg::CML_READ) |=> digital_sel)
        else $error("pin not digital in exchange");
    a_fmt_write: assert property (@(posedge clk) disable iff (rst)
        (ce && fmt_set) |=> fmt_r == $past(cmd_wdata[7:5]))
        else $error("format not stored");
    a_pwm_drive: assert property (@(posedge clk) disable iff (rst)
        (ce && pwm_mode && !exch) |=> (digital_sel && pin_digital == $past(pwm_r)))
        else $error("pwm not on driver");
    // The reply checks below name ce in every cycle before the one they check, since a low enable legally stretches a reply.
    a_seal_reload: assert property (@(posedge clk) disable iff (rst)
        (ce && seal_load_r && mif.rdata[0]) |=> seal_r)
        else $error("seal not reloaded from memory");
    a_seal_set: assert property (@(posedge clk) disable iff (rst)
        (ce && seal_set) |=> seal_r)
        else $error("seal write did not lock");
    a_sealed_wr_nack: assert property (@(posedge clk) disable iff (rst)
        (ce && seal_r && take && state_r == cml_pkg::CML_IDLE && cmd_write) |=> (reply_valid && reply_nack && reply_data == cml_pkg::NACK_WORD))
        else $error("sealed write not refused");
    a_sealed_rd_word: assert property (@(posedge clk) disable iff (rst)
        (ce && seal_r && take && state_r == cml_pkg::CML_IDLE && !cmd_write) ##1 ce |=> (reply_data == cml_pkg::NACK_WORD))
        else $error("sealed read returned data");
    a_read_reply: assert property (@(posedge clk) disable iff (rst)
        (ce && do_read && !blocked) ##1 ce |=> (reply_valid && !reply_nack))
        else $error("read reply missing");
    a_adc_snap: assert property (@(posedge clk) disable iff (rst)
        (ce && do_read && !blocked && cmd_addr == cml_pkg::ADDR_ADC_RD) ##1 ce |=> (reply_data == $past(adc_filtered, 2)))
        else $error("readout not a snapshot");
    a_reply_single: assert property (@(posedge clk) disable iff (rst)
        (ce && reply_valid) |=> !reply_valid)
        else $error("reply longer than one cycle");
    a_reply_digital: assert property (@(posedge clk) disable iff (rst)
        reply_valid |-> digital_sel)
        else $error("reply while pin analog");
    a_idle_analog: assert property (@(posedge clk) disable iff (rst)
        (ce && state_r == cml_pkg::CML_IDLE && !take && !pwm_mode) |=> !digital_sel)
        else $error("pin not back to analog");
    a_unsel_no_write: assert property (@(posedge clk) disable iff (rst)
        (cmd_valid && !selected_r) |-> !mif.we)
        else $error("unselected write reached memory");
    a_duty_latch: assert property (@(posedge clk) disable iff (rst)
        (ce && step_end && slot_r == 11'h7FF) |=> duty_r == $past(adc_filtered[cml_pkg::DW-1 -: PW]))
        else $error("duty not latched at period end");
    a_slot_advance: assert property (@(posedge clk) disable iff (rst)
        (ce && step_end) |=> slot_r == $past(slot_r) + 11'h001)
        else $error("slot counter skipped");
    a_pwm_plain: assert property (@(posedge clk) disable iff (rst)
        (ce && fmt_r == cml_pkg::FMT_PWM) |=> pwm_r == ($past(slot_r) < $past(duty_r)))
        else $error("pulse level wrong");
    a_pwm_inverted: assert property (@(posedge clk) disable iff (rst)
        (ce && fmt_r == cml_pkg::FMT_PWM_INV) |=> pwm_r == ($past(slot_r) >= $past(duty_r)))
        else $error("inverted pulse level wrong");
    a_sealed_fmt_kept: assert property (@(posedge clk) disable iff (rst)
        (ce && seal_r) |=> $stable(fmt_r))
        else $error("format changed while sealed");
endmodule : cml_access

/* tb/cml_prog_model.sv */
// Purpose: Programmer model that selects one device and sends decoded commands.
// Assumes: Every line changes 1 ns after the rising clock edge.
// Notes:   Released command lines show inverted values so stale data never looks valid.
`timescale 1ns/10ps
module cml_prog_model (
    // Clock and answer
    input  wire logic              clk,
    input  wire logic              reply_valid,
    // Command lines
    output logic                   cmd_valid,
    output logic                   cmd_write,
    output logic [cml_pkg::AW-1:0] cmd_addr,
    output logic [cml_pkg::DW-1:0] cmd_wdata,
    // Selection and exchange end
    output logic                   sel_pin,
    output logic                   reply_done
);
    initial begin
        cmd_valid  = 1'b0;
        cmd_write  = 1'b0;
        cmd_addr   = 5'h00;
        cmd_wdata  = 16'h0000;
        sel_pin    = 1'b0;
        reply_done = 1'b0;
    end

    // Selection passes a three-stage synchroniser, so six edges are allowed.
    task automatic select(input logic s);
        sel_pin = s;
        repeat (6) @(posedge clk);
        #1;
    endtask : select

    task automatic send(input logic w, input logic [4:0] a, input logic [15:0] d, input bit ans);
        int n;
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr  = a;
        cmd_wdata = d;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        cmd_write = ~w;
        cmd_addr  = ~a;
        cmd_wdata = ~d;
        n = 0;
        while (ans && reply_valid !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        // A slow encoder ends the exchange later; the next command waits for idle.
        if (ans) begin
            repeat ($urandom_range(3)) begin
                @(posedge clk);
                #1;
            end
            reply_done = 1'b1;
            @(posedge clk);
            #1;
            reply_done = 1'b0;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask : send
endmodule : cml_prog_model

/* tb/tb.sv */
// Purpose: Self-checking bench for the calibration memory access block.
// Assumes: Shortened pulse-width slot of 2 cycles.
// Notes:   Expected replies are queued by the driver and matched by a monitor.
`timescale 1ns/10ps
module tb;
    localparam int PSTEP = 2;
    logic clk = 1'b0;
    logic rst, ce, reply_bit, cmd_valid, cmd_write, sel_pin, reply_done;
    logic reply_valid, reply_nack, digital_sel, pin_digital, sealed, mem_fault, sealed_x;
    logic [4:0]  cmd_addr, a;
    logic [15:0] cmd_wdata, adc, reply_data, d;
    logic [2:0]  out_format;
    logic [17:0] ex;
    logic [17:0] exp_q [$];
    int err_total, samples_checked, cyc, per, hi, hi2;

    always #20 clk = ~clk;

    cml_prog_model prog_u (.clk(clk), .reply_valid(reply_valid), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .sel_pin(sel_pin), .reply_done(reply_done));

    cml_access #(.PWM_STEP(PSTEP)) dut_u (.clk(clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .sel_pin(sel_pin),
        .adc_filtered(adc), .reply_bit(reply_bit), .reply_done(reply_done),
        .reply_valid(reply_valid), .reply_data(reply_data), .reply_nack(reply_nack),
        .digital_sel(digital_sel), .pin_digital(pin_digital), .sealed(sealed),
        .mem_fault(mem_fault), .out_format(out_format));

    task automatic cmp16(input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp16

    task automatic cmp1(input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp1

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // A refused access must answer with the fixed word and leave memory alone.
    task automatic wr(input logic [4:0] ad, input logic [15:0] dt);
        exp_q.push_back({1'b0, sealed_x, sealed_x ? cml_pkg::NACK_WORD : dt});
        prog_u.send(1'b1, ad, dt, 1'b1);
    endtask : wr

    task automatic rd(input logic [4:0] ad, input logic [15:0] dt);
        exp_q.push_back({!sealed_x && ad != cml_pkg::ADDR_ADC_RD, sealed_x, sealed_x ? cml_pkg::NACK_WORD : dt});
        prog_u.send(1'b0, ad, 16'h0000, 1'b1);
    endtask : rd

    task automatic measure(output int p, output int h);
        logic pv;
        int n;
        n = 0;
        while (pin_digital !== 1'b0 && n < 9000) begin @(posedge clk); n++; end
        while (pin_digital !== 1'b1 && n < 9000) begin @(posedge clk); n++; end
        p = 1;
        h = 1;
        pv = 1'b1;
        while (p < 9000) begin
            @(posedge clk);
            if (pv === 1'b0 && pin_digital === 1'b1) break;
            p++;
            h += (pin_digital === 1'b1);
            pv = pin_digital;
        end
    endtask : measure

    // Monitor: every reply is matched against the oldest queued expectation.
    always @(posedge clk) begin
        cyc++;
        if (reply_valid === 1'b1) begin
            if (exp_q.size() == 0) cmp1(1'b0, 1'b1);
            else begin
                ex = exp_q.pop_front();
                cmp16(ex[15:0], reply_data);
                cmp1(ex[16], reply_nack);
                cmp1(1'b1, digital_sel);
                cmp1(reply_bit, pin_digital);
                if (ex[17]) cmp1(1'b0, mem_fault);
            end
        end
        if (cyc == 60000) begin
            err_total++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, 0, cyc);
            tally_and_finish();
        end
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        reply_bit = 1'b0;
        adc = 16'h4000;
        sealed_x = 1'b0;
        void'($urandom(32'h0000FC13));
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        prog_u.select(1'b1);
        wr(cml_pkg::ADDR_MODE, cml_pkg::MODE_RESET);
        cmp1(1'b0, digital_sel);
        for (int i = 0; i < 6; i++) begin
            a = 5'(1 + $urandom_range(28));
            d = 16'($urandom);
            reply_bit = 1'($urandom);
            wr(a, d);
            rd(a, d);
        end
        adc = 16'($urandom);
        d = adc;
        fork
            rd(cml_pkg::ADDR_ADC_RD, d);
            begin repeat (2) @(posedge clk); #1 adc = ~adc; end
        join
        prog_u.select(1'b0);
        prog_u.send(1'b1, cml_pkg::ADDR_MODE, 16'h00C0, 1'b0);
        prog_u.select(1'b1);
        // A command presented while the enable is low must leave no trace.
        ce = 1'b0;
        prog_u.send(1'b1, cml_pkg::ADDR_MODE, 16'h00E0, 1'b0);
        ce = 1'b1;
        rd(cml_pkg::ADDR_MODE, cml_pkg::MODE_RESET);
        adc = 16'h4000;
        wr(cml_pkg::ADDR_MODE, 16'h00C0);
        cmp16({13'h0000, cml_pkg::FMT_PWM}, {13'h0000, out_format});
        cmp1(1'b1, digital_sel);
        measure(per, hi);
        measure(per, hi);
        cmp16(16'((1 << cml_pkg::PWM_RES_BITS) * PSTEP), 16'(per));
        cmp16(16'((16'h4000 >> 5) * PSTEP), 16'(hi));
        wr(cml_pkg::ADDR_MODE, 16'h00E0);
        measure(per, hi2);
        measure(per, hi2);
        cmp16(16'((1 << cml_pkg::PWM_RES_BITS) * PSTEP), 16'(per));
        cmp16(16'(((1 << cml_pkg::PWM_RES_BITS) - (16'h4000 >> 5)) * PSTEP), 16'(hi2));
        wr(cml_pkg::ADDR_MODE, cml_pkg::MODE_RESET);
        cmp1(1'b0, digital_sel);
        wr(cml_pkg::ADDR_SEAL, 16'h0001);
        sealed_x = 1'b1;
        cmp1(1'b1, sealed);
        wr(cml_pkg::ADDR_MODE, 16'h00C0);
        cmp16(16'h0000, {13'h0000, out_format});
        rd(cml_pkg::ADDR_MODE, cml_pkg::MODE_RESET);
        rd(cml_pkg::ADDR_ADC_RD, 16'h0000);
        rd(cml_pkg::ADDR_TRACK_LO, 16'h0000);
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp1(1'b1, sealed);
        prog_u.select(1'b1);
        wr(cml_pkg::ADDR_SEAL, 16'h0000);
        cmp1(1'b1, sealed);
        repeat (4) @(posedge clk);
        cmp16(16'h0000, 16'(exp_q.size()));
        tally_and_finish();
    end
endmodule : tb
